/* rtl/fdc_host_port.sv */
// Host register port and head stepping logic of the floppy controller
// Behaviour
// [RULE_01] Accesses are honoured only while chip select is low.
// [RULE_02] A low write strobe requests a register write.
// [RULE_03] A low read strobe requests a register read.
// [RULE_04] Register select, qualified by the strobes, picks the register.
// [RULE_05] Code 00 reads status, writes command; code 01 reads/writes track.
// [RULE_06] Code 10 reaches sector, code 11 reaches the data register.
// [RULE_07] The data bus is three-state and carries inverted bytes.
// [RULE_08] Step pulses on the step output are active high.
// [RULE_09] Direction is high stepping in, low stepping out.
// [RULE_10] Early output flags a write pulse that must be shifted earlier.
// [RULE_11] Eleven one-byte commands written to the command register drive it.
// [RULE_12] Sector length is selectable: 128, 256, 512 or 1024 bytes.
// [RULE_13] Reset loads command 03, clears not-ready; release restores, sector 01.
// [RULE_14] The bus is driven only while chip select and read are low.
// [RULE_15] The host never asserts read and write together.
`timescale 1ns/10ps
module fdc_host_port
   import fdc_pkg::*;
#(
   parameter int unsigned STEP_BASE_CYC = STEP_BASE_MS * 1000000 / CLK_PERIOD_NS
)(
   input  wire logic        sys_clk_in,
   input  wire logic        nrst_in,
   input  wire logic        cs_n_in,
   input  wire logic        rd_n_in,
   input  wire logic        wr_n_in,
   input  wire logic [1:0]  register_select_in,
   input  wire logic [7:0]  inverted_data_bus_in,
   input  wire logic        drive_ready_in,
   input  wire logic        track_zero_n_in,
   output logic      [7:0]  inverted_data_bus_out,
   output logic             inverted_data_bus_oe_out,
   output logic             step_out,
   output logic             step_direction_out,
   output logic             early_out,
   output logic      [10:0] sector_bytes_out,
   output logic             busy_out
);

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   localparam logic [14:0] SYNC_RST = 15'h7_C00; // Idle pin levels: no false track zero

   logic [14:0] pins_s;
   logic        cs_s;
   logic        rd_s;
   logic        wr_s;
   logic        rdy_s;
   logic        trk0_n_s;
   logic [1:0]  sel_s;
   logic [7:0]  din_s;

   fdc_sync #(.WIDTH(15), .RST_VAL(SYNC_RST)) u_sync (
      .sys_clk_in (sys_clk_in),
      .nrst_in    (nrst_in),
      .async_in   ({cs_n_in, rd_n_in, wr_n_in, drive_ready_in, track_zero_n_in,
                    register_select_in, inverted_data_bus_in}),
      .sync_out   (pins_s)
   );

   assign cs_s     = pins_s[14];
   assign rd_s     = pins_s[13];
   assign wr_s     = pins_s[12];
   assign rdy_s    = pins_s[11];
   assign trk0_n_s = pins_s[10];
   assign sel_s    = pins_s[9:8];
   assign din_s    = pins_s[7:0];

   // ----------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------
   logic       wr_prev_r;
   logic       wr_req;
   logic       wr_take;
   logic       rd_sel;
   logic [7:0] wbyte;

   // Read wins nothing here: a cycle with both strobes low is treated as idle
   assign wr_req  = !cs_s && !wr_s && rd_s;                   // [RULE_01] [RULE_02] [RULE_15]
   assign rd_sel  = !cs_s && !rd_s && wr_s;                   // [RULE_01] [RULE_03] [RULE_15]
   assign wr_take = wr_req && !wr_prev_r;
   assign wbyte   = ~din_s;                                   // [RULE_07]

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wr_prev_r <= 1'b0;
      end else begin
         wr_prev_r <= wr_req;
      end
   end

   // ----------------------------------------------------------------------
   // Command register and start request
   // ----------------------------------------------------------------------
   fdc_state_t state_r;
   logic [7:0] cmd_r;
   logic       go_r;
   logic       busy_r;
   logic       cmd_load;
   logic       go_take;
   fdc_cmd_t   kind;
   fdc_cmd_t   new_kind;

   assign kind     = fdc_cmd_kind(cmd_r);                     // [RULE_11]
   assign new_kind = fdc_cmd_kind(wbyte);
   // A busy controller only listens to force interrupt
   assign cmd_load = wr_take && sel_s == SEL_STAT_CMD
                     && (!busy_r || new_kind == CK_FORCE_INT); // [RULE_04] [RULE_05]
   assign go_take  = go_r && (state_r == ST_IDLE || kind == CK_FORCE_INT);

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cmd_r <= CMD_RST_VAL;                                // [RULE_13]
         go_r  <= 1'b1;                                       // [RULE_13]
      end else begin
         if (cmd_load) begin
            cmd_r <= wbyte;
         end
         // A new load in the take cycle keeps the request alive
         if (cmd_load) begin
            go_r <= 1'b1;
         end else if (go_take) begin
            go_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Sector, data and status registers
   // ----------------------------------------------------------------------
   logic [7:0] sect_r;
   logic [7:0] data_r;
   logic [7:0] track_r;
   logic       nrdy_r;
   logic [7:0] status_w;

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sect_r <= SECTOR_RST_VAL;                            // [RULE_13]
         data_r <= DATA_RST_VAL;
      end else begin
         if (wr_take && sel_s == SEL_SECTOR) begin
            sect_r <= wbyte;                                  // [RULE_06]
         end
         if (wr_take && sel_s == SEL_DATA) begin
            data_r <= wbyte;                                  // [RULE_06]
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         nrdy_r <= 1'b0;                                      // [RULE_13]
      end else begin
         nrdy_r <= !rdy_s;
      end
   end

   always_comb begin
      status_w                = 8'h00;
      status_w[STAT_NRDY_BIT] = nrdy_r;
      status_w[STAT_TRK0_BIT] = !trk0_n_s;
      status_w[STAT_BUSY_BIT] = busy_r;
   end

   // ----------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         inverted_data_bus_out    <= 8'hFF;
         inverted_data_bus_oe_out <= 1'b0;
      end else begin
         inverted_data_bus_oe_out <= rd_sel;                  // [RULE_14]
         unique case (sel_s)                                  // [RULE_04]
            SEL_STAT_CMD: inverted_data_bus_out <= ~status_w; // [RULE_05] [RULE_07]
            SEL_TRACK:    inverted_data_bus_out <= ~track_r;  // [RULE_05]
            SEL_SECTOR:   inverted_data_bus_out <= ~sect_r;   // [RULE_06]
            SEL_DATA:     inverted_data_bus_out <= ~data_r;   // [RULE_06]
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Controller sequencer
   // ----------------------------------------------------------------------
   logic [22:0] tmr_r;
   logic [22:0] gap_lim;
   logic [7:0]  nsteps_r;
   logic [2:0]  bits_r;
   logic [7:0]  sh_r;
   logic        prev_r;
   logic        writing;

   assign gap_lim = 23'(STEP_BASE_CYC * STEP_RATE_MS[cmd_r[1:0]]);
   assign writing = kind == CK_WR_SECT || kind == CK_WR_TRACK;
   assign busy_out = busy_r;

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_r            <= ST_IDLE;
         busy_r             <= 1'b0;
         step_out           <= 1'b0;
         step_direction_out <= 1'b0;
         early_out          <= 1'b0;
         tmr_r              <= '0;
         nsteps_r           <= '0;
         bits_r             <= '0;
         sh_r               <= '0;
         prev_r             <= 1'b0;
         track_r            <= TRACK_RST_VAL;
         sector_bytes_out   <= '0;
      end else if (go_take && kind == CK_FORCE_INT) begin
         state_r   <= ST_IDLE;
         busy_r    <= 1'b0;
         step_out  <= 1'b0;
         early_out <= 1'b0;
      end else begin
         if (!busy_r && wr_take && sel_s == SEL_TRACK) begin
            track_r <= wbyte;                                 // [RULE_05]
         end
         unique case (state_r)
            ST_IDLE: if (go_take) begin
               busy_r   <= 1'b1;
               nsteps_r <= '0;
               tmr_r    <= '0;
               bits_r   <= '0;
               sh_r     <= data_r;
               prev_r   <= 1'b0;
               if (kind inside {CK_RD_SECT, CK_WR_SECT, CK_RD_ADDR,
                                CK_RD_TRACK, CK_WR_TRACK}) begin
                  sector_bytes_out <= fdc_sector_bytes(data_r[1:0]); // [RULE_12]
                  state_r          <= ST_XFER;
               end else begin
                  state_r <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               state_r  <= ST_PULSE;
               step_out <= 1'b1;                              // [RULE_08]
               tmr_r    <= '0;
               unique case (kind)
                  CK_RESTORE: begin
                     step_direction_out <= 1'b0;              // [RULE_09] [RULE_13]
                     if (!trk0_n_s || nsteps_r == RESTORE_MAX) begin
                        track_r  <= TRACK_RST_VAL;
                        step_out <= 1'b0;
                        busy_r   <= 1'b0;
                        state_r  <= ST_IDLE;
                     end
                  end
                  CK_SEEK: begin
                     step_direction_out <= data_r > track_r;  // [RULE_09]
                     if (data_r == track_r) begin
                        step_out <= 1'b0;
                        busy_r   <= 1'b0;
                        state_r  <= ST_IDLE;
                     end
                  end
                  default: begin
                     if (kind == CK_STEP_IN) begin
                        step_direction_out <= 1'b1;           // [RULE_09]
                     end else if (kind == CK_STEP_OUT) begin
                        step_direction_out <= 1'b0;           // [RULE_09]
                     end
                     if (nsteps_r != 8'h00) begin
                        step_out <= 1'b0;
                        busy_r   <= 1'b0;
                        state_r  <= ST_IDLE;
                     end
                  end
               endcase
            end
            ST_PULSE: begin
               tmr_r <= tmr_r + 23'h00_0001;
               if (tmr_r == 23'(STEP_PULSE_CYC - 1)) begin
                  step_out <= 1'b0;                           // [RULE_08]
                  tmr_r    <= '0;
                  state_r  <= ST_GAP;
               end
            end
            ST_GAP: begin
               tmr_r <= tmr_r + 23'h00_0001;
               if (tmr_r >= gap_lim - 23'h00_0001) begin
                  nsteps_r <= nsteps_r + 8'h01;
                  state_r  <= ST_CHECK;
                  // Seek always tracks; plain steps only with the update flag
                  if (kind == CK_SEEK || cmd_r[CMD_UPD_BIT]) begin
                     track_r <= step_direction_out ? track_r + 8'h01 : track_r - 8'h01;
                  end
               end
            end
            ST_XFER: begin
               tmr_r     <= tmr_r + 23'h00_0001;
               // A one after a zero and ahead of another one is the pattern shifted early
               early_out <= writing && sh_r[7] && sh_r[6] && !prev_r; // [RULE_10]
               if (tmr_r == 23'(BIT_CELL_CYC - 1)) begin
                  tmr_r  <= '0;
                  prev_r <= sh_r[7];
                  sh_r   <= {sh_r[6:0], 1'b0};
                  bits_r <= bits_r + 3'h1;
                  if (bits_r == 3'h7) begin
                     early_out <= 1'b0;
                     busy_r    <= 1'b0;
                     state_r   <= ST_IDLE;
                  end
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   logic [11:0] pulse_len_r;

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pulse_len_r <= '0;
      end else begin
         pulse_len_r <= step_out ? pulse_len_r + 12'h001 : 12'h000;
      end
   end

   a_cs_ignore: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // [RULE_01]
      cs_s |=> $stable(cmd_r) && $stable(sect_r) && $stable(data_r))
      else $error("register changed while deselected");
   a_cmd_load: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // [RULE_05]
      wr_take && sel_s == SEL_STAT_CMD && !busy_r |=> cmd_r == ~$past(din_s))
      else $error("command write not loaded inverted");
   a_sector_wr: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // [RULE_06]
      wr_take && sel_s == SEL_SECTOR |=> sect_r == ~$past(din_s))
      else $error("sector write not loaded inverted");
   a_status_read: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // [RULE_05]
      rd_sel && sel_s == SEL_STAT_CMD |=> inverted_data_bus_out == ~$past(status_w))
      else $error("status read wrong");
   a_data_read: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // [RULE_07]
      rd_sel && sel_s == SEL_DATA |=> inverted_data_bus_out == ~$past(data_r))
      else $error("data read not inverted");
   a_bus_drive: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // [RULE_14]
      inverted_data_bus_oe_out == $past(!cs_s && !rd_s && wr_s))
      else $error("bus driven outside read");
   a_step_width: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // [RULE_08]
      $fell(step_out) |-> pulse_len_r == 12'(STEP_PULSE_CYC))
      else $error("step pulse width wrong");
   a_dir_steady: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // [RULE_09]
      step_out && $past(step_out) |-> $stable(step_direction_out))
      else $error("direction moved during step");
   a_seek_dir: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // [RULE_09]
      $rose(step_out) && kind == CK_SEEK |-> step_direction_out == (data_r > track_r))
      else $error("seek direction wrong");
   a_early_write: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // [RULE_10]
      early_out |-> state_r == ST_XFER && writing)
      else $error("early outside write");

endmodule : fdc_host_port

/* rtl/fdc_pkg.sv */
// Constants, types and helpers shared by the floppy controller host port
package fdc_pkg;

   // ----------------------------------------------------------------------
   // Register select codes
   // ----------------------------------------------------------------------
   localparam logic [1:0] SEL_STAT_CMD = 2'h0;
   localparam logic [1:0] SEL_TRACK    = 2'h1;
   localparam logic [1:0] SEL_SECTOR   = 2'h2;
   localparam logic [1:0] SEL_DATA     = 2'h3;

   // ----------------------------------------------------------------------
   // Reset values and status bit positions
   // ----------------------------------------------------------------------
   localparam logic [7:0] CMD_RST_VAL    = 8'h03;
   localparam logic [7:0] SECTOR_RST_VAL = 8'h01;
   localparam logic [7:0] TRACK_RST_VAL  = 8'h00;
   localparam logic [7:0] DATA_RST_VAL   = 8'h00;
   localparam int         STAT_BUSY_BIT  = 0;
   localparam int         STAT_TRK0_BIT  = 2;
   localparam int         STAT_NRDY_BIT  = 7;
   localparam int         CMD_UPD_BIT    = 4;
   localparam logic [7:0] RESTORE_MAX    = 8'hFF;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int STEP_PULSE_NS = 4000;
   localparam int STEP_PULSE_CYC = (STEP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BIT_CELL_NS   = 2000;
   localparam int BIT_CELL_CYC  = BIT_CELL_NS / CLK_PERIOD_NS;
   localparam int STEP_BASE_MS  = 1;
   localparam logic [3:0] STEP_RATE_MS [4] = '{4'h3, 4'h6, 4'hA, 4'hF};

   // ----------------------------------------------------------------------
   // Command classes and controller states
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      CK_RESTORE, CK_SEEK, CK_STEP, CK_STEP_IN, CK_STEP_OUT, CK_RD_SECT,
      CK_WR_SECT, CK_RD_ADDR, CK_FORCE_INT, CK_RD_TRACK, CK_WR_TRACK
   } fdc_cmd_t;

   typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_PULSE, ST_GAP, ST_XFER} fdc_state_t;

   function automatic fdc_cmd_t fdc_cmd_kind(input logic [7:0] cmd);
      fdc_cmd_t k;
      k = CK_RESTORE;
      unique case (cmd[7:4])
         4'h0: k = CK_RESTORE;
         4'h1: k = CK_SEEK;
         4'h2, 4'h3: k = CK_STEP;
         4'h4, 4'h5: k = CK_STEP_IN;
         4'h6, 4'h7: k = CK_STEP_OUT;
         4'h8, 4'h9: k = CK_RD_SECT;
         4'hA, 4'hB: k = CK_WR_SECT;
         4'hC: k = CK_RD_ADDR;
         4'hD: k = CK_FORCE_INT;
         4'hE: k = CK_RD_TRACK;
         4'hF: k = CK_WR_TRACK;
      endcase
      return k;
   endfunction : fdc_cmd_kind

   // Length code 0..3 gives 128, 256, 512 or 1024 bytes
   function automatic logic [10:0] fdc_sector_bytes(input logic [1:0] code);
      return 11'h080 << code;
   endfunction : fdc_sector_bytes

endpackage : fdc_pkg

/* rtl/fdc_sync.sv */
// Two-stage synchroniser for the asynchronous pins of the host port
`timescale 1ns/10ps
module fdc_sync
   import fdc_pkg::*;
#(
   parameter int              WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
)(
   input  wire logic             sys_clk_in,
   input  wire logic             nrst_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   // ----------------------------------------------------------------------
   // Per-bit flop pair; stage one feeds stage two only
   // ----------------------------------------------------------------------
   logic [WIDTH-1:0] meta_r;

   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge sys_clk_in or negedge nrst_in) begin
         if (!nrst_in) begin
            meta_r[i]   <= RST_VAL[i];
            sync_out[i] <= RST_VAL[i];
         end else begin
            meta_r[i]   <= async_in[i];
            sync_out[i] <= meta_r[i];
         end
      end
   end

endmodule : fdc_sync

/* tb/fdc_drive_model.sv */
// Floppy drive model: head position, ready and track-zero lines
`timescale 1ns/10ps
module fdc_drive_model #(
   parameter int START_TRACK = 2
)(
   input  wire logic       sys_clk_in,
   input  wire logic       step_in,
   input  wire logic       step_direction_in,
   output logic            drive_ready_out,
   output logic            track_zero_n_out,
   output logic      [7:0] head_track_out
);
   logic step_r;

   initial head_track_out = START_TRACK[7:0];
   initial step_r = 1'b0;
   assign drive_ready_out  = 1'b1;
   assign track_zero_n_out = (head_track_out != 8'h00);

   // Head moves once per rising edge of the step pulse; it cannot go below track 0
   always @(posedge sys_clk_in) begin
      step_r <= step_in;
      if (step_in && !step_r) begin
         if (step_direction_in) begin
            head_track_out <= head_track_out + 8'h01;
         end else if (head_track_out != 8'h00) begin
            head_track_out <= head_track_out - 8'h01;
         end
      end
   end
endmodule : fdc_drive_model

/* tb/fdc_host_port_tb.sv */
// Self-checking bench for the floppy controller host port
`timescale 1ns/10ps
module fdc_host_port_tb;
   import fdc_pkg::*;
   logic        sys_clk, nrst_n, cs_n, rd_n, wr_n, host_oe, ready, trk0_n;
   logic        dut_oe, step, dir, early, busy, step_d, early_d;
   logic [1:0]  sel;
   logic [7:0]  host_byte, bus_wire, dut_bus, head;
   logic [10:0] sect_bytes;
   int          n_fail, n_compared, n_step, n_dir_in, n_early;
   logic [7:0]  cmds [6] = '{8'h30, 8'h00, 8'hC0, 8'hD0, 8'hE0, 8'hF0};

   // Released bus floats up to all ones, as a pulled-up bus would
   assign bus_wire = dut_oe ? dut_bus : (host_oe ? host_byte : 8'hFF);

   fdc_host_port #(.STEP_BASE_CYC(20)) i_dut (
      .sys_clk_in(sys_clk), .nrst_in(nrst_n), .cs_n_in(cs_n), .rd_n_in(rd_n),
      .wr_n_in(wr_n), .register_select_in(sel), .inverted_data_bus_in(bus_wire),
      .drive_ready_in(ready), .track_zero_n_in(trk0_n),
      .inverted_data_bus_out(dut_bus), .inverted_data_bus_oe_out(dut_oe),
      .step_out(step), .step_direction_out(dir), .early_out(early),
      .sector_bytes_out(sect_bytes), .busy_out(busy));

   fdc_drive_model #(.START_TRACK(2)) i_drive (
      .sys_clk_in(sys_clk), .step_in(step), .step_direction_in(dir),
      .drive_ready_out(ready), .track_zero_n_out(trk0_n), .head_track_out(head));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      step_d <= step;
      early_d <= early;
      if (step && !step_d) begin
         n_step++;
         n_dir_in += int'(dir);
      end
      if (early && !early_d) n_early++;
   end

   // ----------------------------------------
   // Bus, check and wait tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [10:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic conclude();
      $display("Compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude

   // Strobe and data held for 5 cycles, well past the 3-edge capture path
   task automatic wr_reg(input logic [1:0] s, input logic [7:0] v, input logic c = 1'b0);
      @(negedge sys_clk);
      cs_n = c;
      wr_n = 1'b0;
      sel = s;
      host_byte = ~v;
      host_oe = 1'b1;
      repeat (5) @(negedge sys_clk);
      cs_n = 1'b1;
      wr_n = 1'b1;
      host_oe = 1'b0;
      repeat (4) @(negedge sys_clk);
   endtask : wr_reg

   task automatic rd_reg(input logic [1:0] s, input logic [7:0] e, input string what,
                         input logic c = 1'b0);
      @(negedge sys_clk);
      cs_n = c;
      rd_n = 1'b0;
      sel = s;
      repeat (4) @(negedge sys_clk);
      check({what, " oe"}, {10'h000, dut_oe}, {10'h000, ~c});
      if (!c) check(what, {3'h0, ~bus_wire}, {3'h0, e});
      cs_n = 1'b1;
      rd_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      check({what, " oe off"}, {10'h000, dut_oe}, 11'h000);
   endtask : rd_reg

   task automatic wait_idle(input int lim);
      int i;
      for (i = 0; i < lim && busy !== 1'b0; i++) @(negedge sys_clk);
      if (i == lim) begin
         n_fail++;
         $display("Error busy expected 0 seen 1");
         conclude();
      end
   endtask : wait_idle

   task automatic cmd(input logic [7:0] v);
      wr_reg(SEL_STAT_CMD, v);
      wait_idle(6000);
   endtask : cmd

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      nrst_n = 1'b0;
      {cs_n, rd_n, wr_n, host_oe, sel, host_byte} = {4'hE, 2'h0, 8'h00};
      {n_fail, n_compared, n_step, n_dir_in, n_early} = '0;
      repeat (8) @(negedge sys_clk);
      check("oe in reset", {10'h000, dut_oe}, 11'h000);
      check("step in reset", {10'h000, step}, 11'h000);
      nrst_n = 1'b1;
      repeat (2) @(negedge sys_clk);
      wait_idle(6000);
      check("restore steps", 11'(n_step), 11'd2);
      check("restore dir", 11'(n_dir_in), 11'd0);
      rd_reg(SEL_SECTOR, SECTOR_RST_VAL, "sector");
      rd_reg(SEL_TRACK, 8'h00, "track");
      rd_reg(SEL_STAT_CMD, 8'h01 << STAT_TRK0_BIT, "status");
      for (int s = 1; s < 4; s++) begin
         wr_reg(2'(s), 8'h96 + 8'(s));
         rd_reg(2'(s), 8'h96 + 8'(s), "reg");
      end
      wr_reg(SEL_SECTOR, 8'h77, 1'b1);
      rd_reg(SEL_SECTOR, 8'h98, "deselected", 1'b1);
      rd_reg(SEL_SECTOR, 8'h98, "sector kept");
      wr_reg(SEL_TRACK, 8'h00);
      wr_reg(SEL_DATA, 8'h02);
      n_step = 0;
      n_dir_in = 0;
      cmd(8'h10);
      check("seek steps", 11'(n_step), 11'd2);
      check("seek dir", 11'(n_dir_in), 11'd2);
      check("head", {3'h0, head}, 11'h002);
      cmd(8'h70);
      rd_reg(SEL_TRACK, 8'h01, "step out");
      check("head out", {3'h0, head}, 11'h001);
      cmd(8'h50);
      rd_reg(SEL_TRACK, 8'h02, "step in");
      for (int c = 0; c < 4; c++) begin
         wr_reg(SEL_DATA, 8'(c));
         wr_reg(SEL_STAT_CMD, 8'h80);
         check("length", sect_bytes, 11'h080 << c);
         wait_idle(6000);
      end
      // 0110_1100 sent MSB first: two bits have a 0 before and a 1 after
      wr_reg(SEL_DATA, 8'h6C);
      n_early = 0;
      cmd(8'hA0);
      check("early", 11'(n_early), 11'd2);
      foreach (cmds[i]) cmd(cmds[i]);
      rd_reg(SEL_TRACK, 8'h00, "restored");
      check("head home", {3'h0, head}, 11'h000);
      conclude();
   end
endmodule : fdc_host_port_tb
